// >>> hw/cpu_regs_pkg.sv
// Package: register selectors, view codes, flag positions and reset values
package cpu_regs_pkg;

  localparam int DATA_W = 32;
  localparam int NUM_BANKS = 2;
  localparam int BANK_REGS = 10;
  localparam int FLAG_STACK_SEL_BIT = 7;
  localparam int FLAG_BANK_SEL_BIT = 8;
  localparam logic [6:0] SW_INT_CLEARS_MAX = 7'h7f;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
  localparam logic [31:0] FLAG_RESET = 32'h0000_0000;

  // Banked register index within a bank
  localparam logic [3:0] IDX_DATA_PAIR_ZERO = 4'h0;
  localparam logic [3:0] IDX_DATA_PAIR_ONE = 4'h1;
  localparam logic [3:0] IDX_DATA_PAIR_TWO = 4'h2;
  localparam logic [3:0] IDX_DATA_PAIR_THREE = 4'h3;
  localparam logic [3:0] IDX_ADDR_REG_ZERO = 4'h4;
  localparam logic [3:0] IDX_STATIC_BASE = 4'h8;
  localparam logic [3:0] IDX_FRAME_BASE = 4'h9;

  // Selector space seen by the datapath
  localparam logic [4:0] SEL_NEXT_INSTR = 5'h10;
  localparam logic [4:0] SEL_VECTOR_BASE = 5'h11;
  localparam logic [4:0] SEL_USER_SP = 5'h12;
  localparam logic [4:0] SEL_INTR_SP = 5'h13;
  localparam logic [4:0] SEL_ACTIVE_SP = 5'h14;
  localparam logic [4:0] SEL_FLAG_WORD = 5'h15;

  typedef enum logic [2:0] {
    VIEW_WORD,
    VIEW_HALF_HI,
    VIEW_HALF_LO,
    VIEW_BYTE_3,
    VIEW_BYTE_2,
    VIEW_BYTE_1,
    VIEW_BYTE_0
  } view_e;

endpackage

// >>> hw/reg_port_if.sv
// Interface: one write port into a 32-bit register cell with byte enables
`timescale 1ns/1ps
interface reg_port_if;
  logic we;
  logic [3:0] be;
  logic [31:0] wdata;
  logic [31:0] q;
  modport owner (input we, input be, input wdata, output q);
  modport user (output we, output be, output wdata, input q);
endinterface

// >>> hw/byte_reg.sv
// Leaf: one 32-bit register with per-byte write enables
`timescale 1ns/1ps
module byte_reg
  import cpu_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  reg_port_if.owner port
);
  logic [31:0] val_q;
  logic [31:0] val_d;

  // Unaddressed bytes keep their value
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      val_d[8*b +: 8] = (port.we && port.be[b]) ? port.wdata[8*b +: 8] : val_q[8*b +: 8];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      val_q <= RESET_VALUE;
    end else begin
      val_q <= val_d;
    end
  end

  assign port.q = val_q;
endmodule

// >>> hw/cpu_core_register_file.sv
// Top: banked core register set with views, stack pointer and bank selection
// **************************************************************
// **************************************************************
`timescale 1ns/1ps
module cpu_core_register_file
  import cpu_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [4:0] wr_sel,
  input wire view_e wr_view,
  input wire logic [31:0] wr_data,
  input wire logic [4:0] rd_sel,
  input wire view_e rd_view,
  input wire logic [1:0] base_sel,
  input wire logic pc_load,
  input wire logic [31:0] pc_next,
  input wire logic hw_int_accept,
  input wire logic sw_int_exec,
  input wire logic [7:0] sw_int_num,
  output logic [31:0] rd_data,
  output logic [31:0] addr_base,
  output logic [31:0] static_base_reg,
  output logic [31:0] frame_base_reg,
  output logic [31:0] next_instr_pointer,
  output logic [31:0] vector_table_base,
  output logic [31:0] active_stack_pointer,
  output logic [31:0] processor_flag_word
);

  // **************************************************************
  // Selection and view decode
  // **************************************************************
  logic [31:0] flag_q;
  logic [31:0] flag_d;
  wire bank_sel = flag_q[FLAG_BANK_SEL_BIT];
  wire stack_sel = flag_q[FLAG_STACK_SEL_BIT];
  wire is_banked = (wr_sel[4] == 1'b0) && (wr_sel[3:0] <= IDX_FRAME_BASE);
  wire [3:0] wr_idx = wr_sel[3:0];
  wire narrow_ok = (wr_idx <= IDX_DATA_PAIR_THREE);
  wire byte_ok = (wr_idx <= IDX_DATA_PAIR_ONE);
  logic [3:0] wr_be;

  // Byte views only exist on the first two pairs, halves only on data pairs
  always_comb begin
    case (wr_view)
      VIEW_WORD: wr_be = 4'hf;
      VIEW_HALF_HI: wr_be = narrow_ok ? 4'hc : 4'h0;
      VIEW_HALF_LO: wr_be = narrow_ok ? 4'h3 : 4'h0;
      VIEW_BYTE_3: wr_be = byte_ok ? 4'h8 : 4'h0;
      VIEW_BYTE_2: wr_be = byte_ok ? 4'h4 : 4'h0;
      VIEW_BYTE_1: wr_be = byte_ok ? 4'h2 : 4'h0;
      VIEW_BYTE_0: wr_be = byte_ok ? 4'h1 : 4'h0;
      default: wr_be = 4'h0;
    endcase
  end

  // Write data is lane-aligned so a narrow write lands in its own bytes
  logic [31:0] wr_lanes;
  always_comb begin
    case (wr_view)
      VIEW_HALF_HI: wr_lanes = {wr_data[15:0], 16'h0000};
      VIEW_BYTE_3: wr_lanes = {wr_data[7:0], 24'h000000};
      VIEW_BYTE_2: wr_lanes = {8'h00, wr_data[7:0], 16'h0000};
      VIEW_BYTE_1: wr_lanes = {16'h0000, wr_data[7:0], 8'h00};
      default: wr_lanes = wr_data;
    endcase
  end

  // **************************************************************
  // Banked storage
  // **************************************************************
  logic [31:0] bank_q [NUM_BANKS][BANK_REGS];

  genvar gb, gr;
  generate
    for (gb = 0; gb < NUM_BANKS; gb++) begin : g_bank
      for (gr = 0; gr < BANK_REGS; gr++) begin : g_reg
        reg_port_if port ();
        // Only the visible bank accepts writes
        assign port.we = wr_en && is_banked && (wr_idx == 4'(gr)) &&
                         (bank_sel == 1'(gb));
        assign port.be = wr_be;
        assign port.wdata = wr_lanes;
        assign bank_q[gb][gr] = port.q;
        byte_reg u_reg (
          .clk(clk),
          .rstn(rstn),
          .port(port)
        );
      end
    end
  endgenerate

  // **************************************************************
  // Unbanked registers
  // **************************************************************
  logic [31:0] pc_q;
  logic [31:0] pc_d;
  logic [31:0] vtb_q;
  logic [31:0] vtb_d;
  logic [31:0] usp_q;
  logic [31:0] usp_d;
  logic [31:0] isp_q;
  logic [31:0] isp_d;

  wire wr_full = wr_en && (wr_view == VIEW_WORD);
  wire wr_hit_pc = (wr_sel == SEL_NEXT_INSTR);
  wire wr_hit_vtb = (wr_sel == SEL_VECTOR_BASE);
  wire wr_hit_act = (wr_sel == SEL_ACTIVE_SP);
  wire wr_hit_usp = (wr_sel == SEL_USER_SP) || (wr_hit_act && stack_sel);
  wire wr_hit_isp = (wr_sel == SEL_INTR_SP) || (wr_hit_act && !stack_sel);
  wire wr_hit_flag = (wr_sel == SEL_FLAG_WORD);
  wire wr_pc = wr_full && wr_hit_pc;
  wire wr_vtb = wr_full && wr_hit_vtb;
  wire wr_usp = wr_full && wr_hit_usp;
  wire wr_isp = wr_full && wr_hit_isp;
  wire wr_flg = wr_full && wr_hit_flag;
  wire low_sw_int = sw_int_exec && (sw_int_num <= {1'b0, SW_INT_CLEARS_MAX});
  wire clr_stack_sel = hw_int_accept || low_sw_int;

  // Explicit counter load wins over a register-write to the same counter
  assign pc_d = pc_load ? pc_next : (wr_pc ? wr_data : pc_q);
  assign vtb_d = wr_vtb ? wr_data : vtb_q;
  assign usp_d = wr_usp ? wr_data : usp_q;
  assign isp_d = wr_isp ? wr_data : isp_q;

  // Hardware interrupt entry or a soft interrupt numbered 0..7f forces interrupt stack even against a flag write
  always_comb begin
    flag_d = wr_flg ? wr_data : flag_q;
    if (clr_stack_sel) begin
      flag_d[FLAG_STACK_SEL_BIT] = 1'b0;
    end
  end

  // One register per process keeps each reset and load path short
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_q <= RESET_VALUE;
    end else begin
      pc_q <= pc_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vtb_q <= RESET_VALUE;
    end else begin
      vtb_q <= vtb_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      usp_q <= RESET_VALUE;
    end else begin
      usp_q <= usp_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      isp_q <= RESET_VALUE;
    end else begin
      isp_q <= isp_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= FLAG_RESET;
    end else begin
      flag_q <= flag_d;
    end
  end

  // **************************************************************
  // Read path
  // **************************************************************
  wire [3:0] rd_idx = rd_sel[3:0];
  wire [31:0] active_sp = stack_sel ? usp_q : isp_q;
  wire rd_hit_bank = (rd_sel[4] == 1'b0) && (rd_idx <= IDX_FRAME_BASE);
  wire rd_hit_pc = (rd_sel == SEL_NEXT_INSTR);
  wire rd_hit_vtb = (rd_sel == SEL_VECTOR_BASE);
  wire rd_hit_usp = (rd_sel == SEL_USER_SP);
  wire rd_hit_isp = (rd_sel == SEL_INTR_SP);
  wire rd_hit_act = (rd_sel == SEL_ACTIVE_SP);
  wire rd_hit_flag = (rd_sel == SEL_FLAG_WORD);
  logic [31:0] rd_word;
  logic [31:0] rd_view_val;

  always_comb begin
    if (rd_hit_bank) begin
      rd_word = bank_q[bank_sel][rd_idx];
    end else if (rd_hit_pc) begin
      rd_word = pc_q;
    end else if (rd_hit_vtb) begin
      rd_word = vtb_q;
    end else if (rd_hit_usp) begin
      rd_word = usp_q;
    end else if (rd_hit_isp) begin
      rd_word = isp_q;
    end else if (rd_hit_act) begin
      rd_word = active_sp;
    end else if (rd_hit_flag) begin
      rd_word = flag_q;
    end else begin
      rd_word = 32'h0000_0000;
    end
  end

  // Narrow reads are zero extended; an illegal view reads zero
  wire rd_narrow_ok = (rd_sel[4] == 1'b0) && (rd_idx <= IDX_DATA_PAIR_THREE);
  wire rd_byte_ok = (rd_sel[4] == 1'b0) && (rd_idx <= IDX_DATA_PAIR_ONE);
  always_comb begin
    case (rd_view)
      VIEW_WORD: rd_view_val = rd_word;
      VIEW_HALF_HI: rd_view_val = rd_narrow_ok ? {16'h0000, rd_word[31:16]} : 32'h0;
      VIEW_HALF_LO: rd_view_val = rd_narrow_ok ? {16'h0000, rd_word[15:0]} : 32'h0;
      VIEW_BYTE_3: rd_view_val = rd_byte_ok ? {24'h000000, rd_word[31:24]} : 32'h0;
      VIEW_BYTE_2: rd_view_val = rd_byte_ok ? {24'h000000, rd_word[23:16]} : 32'h0;
      VIEW_BYTE_1: rd_view_val = rd_byte_ok ? {24'h000000, rd_word[15:8]} : 32'h0;
      VIEW_BYTE_0: rd_view_val = rd_byte_ok ? {24'h000000, rd_word[7:0]} : 32'h0;
      default: rd_view_val = 32'h0000_0000;
    endcase
  end

  // Address base: 0..3 picks an address register, all from the visible bank
  wire [3:0] base_idx = IDX_ADDR_REG_ZERO + {2'b00, base_sel};
  wire [31:0] addr_base_d = bank_q[bank_sel][base_idx];
  wire [31:0] vis_static_base = bank_q[bank_sel][IDX_STATIC_BASE];
  wire [31:0] vis_frame_base = bank_q[bank_sel][IDX_FRAME_BASE];

  // **************************************************************
  // Registered outputs
  // **************************************************************
  // Read data, address base, both base outputs and active pointer lag their source by one clock; counter, vector base and flags do not
  logic [31:0] rd_data_q;
  logic [31:0] addr_base_q;
  logic [31:0] sb_out_q;
  logic [31:0] fb_out_q;
  logic [31:0] sp_out_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_q <= RESET_VALUE;
    end else begin
      rd_data_q <= rd_view_val;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_base_q <= RESET_VALUE;
    end else begin
      addr_base_q <= addr_base_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sb_out_q <= RESET_VALUE;
    end else begin
      sb_out_q <= vis_static_base;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fb_out_q <= RESET_VALUE;
    end else begin
      fb_out_q <= vis_frame_base;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sp_out_q <= RESET_VALUE;
    end else begin
      sp_out_q <= active_sp;
    end
  end

  assign rd_data = rd_data_q;
  assign addr_base = addr_base_q;
  assign static_base_reg = sb_out_q;
  assign frame_base_reg = fb_out_q;
  assign next_instr_pointer = pc_q;
  assign vector_table_base = vtb_q;
  assign active_stack_pointer = sp_out_q;
  assign processor_flag_word = flag_q;

endmodule

// >>> tb/cpu_core_register_file_monitor.sv
// Assertion checker for the core register set ports
`timescale 1ns/1ps
module cpu_core_register_file_monitor
  import cpu_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [4:0] wr_sel,
  input wire view_e wr_view,
  input wire logic [31:0] wr_data,
  input wire logic [4:0] rd_sel,
  input wire view_e rd_view,
  input wire logic [1:0] base_sel,
  input wire logic pc_load,
  input wire logic [31:0] pc_next,
  input wire logic hw_int_accept,
  input wire logic sw_int_exec,
  input wire logic [7:0] sw_int_num,
  input wire logic [31:0] rd_data,
  input wire logic [31:0] addr_base,
  input wire logic [31:0] static_base_reg,
  input wire logic [31:0] frame_base_reg,
  input wire logic [31:0] next_instr_pointer,
  input wire logic [31:0] vector_table_base,
  input wire logic [31:0] active_stack_pointer,
  input wire logic [31:0] processor_flag_word
);
  // ************************************************
  // Properties
  // ************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Active stack pointer word write with no interrupt, so the active pointer copy cannot switch underneath
  sequence sp_wr_s;
    wr_en && wr_sel == SEL_ACTIVE_SP && wr_view == VIEW_WORD && !hw_int_accept && !sw_int_exec;
  endsequence
  reset_zero_a: assert property ($rose(rstn) |-> processor_flag_word == 32'h0 && active_stack_pointer == 32'h0)
    else $error("outputs not clear after reset");
  pc_load_a: assert property (pc_load |=> next_instr_pointer == $past(pc_next))
    else $error("program counter load lost");
  hw_clear_a: assert property (hw_int_accept |=> !processor_flag_word[7])
    else $error("stack select not cleared by interrupt");
  sw_clear_a: assert property (sw_int_exec && sw_int_num <= 8'h7f |=> !processor_flag_word[7])
    else $error("stack select not cleared by soft interrupt");
  sw_keep_a: assert property (sw_int_exec && sw_int_num > 8'h7f && !hw_int_accept && !wr_en
    |=> $stable(processor_flag_word))
    else $error("high soft interrupt changed flags");
  active_sp_a: assert property (sp_wr_s |=> ##1 active_stack_pointer == $past(wr_data, 2))
    else $error("active stack pointer write lost");
  vector_wr_a: assert property (wr_en && wr_sel == SEL_VECTOR_BASE && wr_view == VIEW_WORD
    |=> vector_table_base == $past(wr_data))
    else $error("vector base write lost");
  flag_read_a: assert property (rd_sel == SEL_FLAG_WORD && rd_view == VIEW_WORD
    |=> rd_data == $past(processor_flag_word))
    else $error("flag word read mismatch");
endmodule
bind cpu_core_register_file cpu_core_register_file_monitor mon_u (.*);

// >>> tb/cpu_core_register_file_tb.sv
// Testbench for the core register set
`timescale 1ns/1ps
module cpu_core_register_file_tb
  import cpu_regs_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, wr_en = 1'b0, pc_load = 1'b0;
  logic hw_int_accept = 1'b0, sw_int_exec = 1'b0;
  logic [4:0] wr_sel = 5'h00, rd_sel = 5'h00;
  view_e wr_view = VIEW_WORD, rd_view = VIEW_WORD;
  logic [31:0] wr_data = 32'h0, pc_next = 32'h0;
  logic [1:0] base_sel = 2'h0;
  logic [7:0] sw_int_num = 8'h00;
  logic [31:0] rd_data, addr_base, static_base_reg, frame_base_reg, next_instr_pointer;
  logic [31:0] vector_table_base, active_stack_pointer, processor_flag_word;
  int fail_count = 0, num_checks = 0;
  always #50 clk = ~clk;
  cpu_core_register_file dut_u (.*);
  // ************************************************
  // Shared tasks
  // ************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] s, input view_e v, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_sel <= s;
    wr_view <= v;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [4:0] s, input view_e v, input logic [31:0] e);
    @(posedge clk);
    rd_sel <= s;
    rd_view <= v;
    @(posedge clk);
    #1;
    chk(rd_data, e);
  endtask
  // Registered outputs lag the write by one edge
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic pulse_int(input logic hw, input logic sw, input logic [7:0] n);
    @(posedge clk);
    hw_int_accept <= hw;
    sw_int_exec <= sw;
    sw_int_num <= n;
    @(posedge clk);
    hw_int_accept <= 1'b0;
    sw_int_exec <= 1'b0;
    #1;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ************************************************
  // Scenarios
  // ************************************************
  task automatic t_views;
    wr(5'h00, VIEW_WORD, 32'h11223344);
    wr(5'h00, VIEW_BYTE_1, 32'h000000ab);
    rd(5'h00, VIEW_WORD, 32'h1122ab44);
    rd(5'h00, VIEW_BYTE_3, 32'h00000011);
    rd(5'h00, VIEW_BYTE_2, 32'h00000022);
    wr(5'h00, VIEW_BYTE_3, 32'h00000099);
    wr(5'h00, VIEW_BYTE_2, 32'h00000088);
    rd(5'h00, VIEW_BYTE_1, 32'h000000ab);
    rd(5'h00, VIEW_BYTE_0, 32'h00000044);
    rd(5'h00, VIEW_WORD, 32'h9988ab44);
    wr(5'h01, VIEW_WORD, 32'h55667788);
    wr(5'h01, VIEW_HALF_LO, 32'h0000beef);
    rd(5'h01, VIEW_HALF_HI, 32'h00005566);
    rd(5'h01, VIEW_WORD, 32'h5566beef);
    wr(5'h01, VIEW_HALF_HI, 32'h0000a5a5);
    rd(5'h01, VIEW_HALF_LO, 32'h0000beef);
    rd(5'h01, VIEW_WORD, 32'ha5a5beef);
    // Address registers take whole words only
    wr(5'h04, VIEW_WORD, 32'h0000abcd);
    wr(5'h04, VIEW_HALF_LO, 32'h00001111);
    rd(5'h04, VIEW_WORD, 32'h0000abcd);
    rd(5'h04, VIEW_HALF_LO, 32'h00000000);
    // Byte views stop at the first two pairs
    wr(5'h02, VIEW_WORD, 32'hcafe0000);
    wr(5'h02, VIEW_BYTE_0, 32'h000000ff);
    rd(5'h02, VIEW_WORD, 32'hcafe0000);
  endtask
  task automatic t_banks;
    wr(5'h08, VIEW_WORD, 32'h0000a000);
    wr(5'h09, VIEW_WORD, 32'h0000b000);
    wr(5'h15, VIEW_WORD, 32'h00000100);
    settle;
    chk(static_base_reg, 32'h0);
    wr(5'h08, VIEW_WORD, 32'h0000c000);
    settle;
    chk(static_base_reg, 32'h0000c000);
    wr(5'h15, VIEW_WORD, 32'h0);
    settle;
    chk(static_base_reg, 32'h0000a000);
    chk(frame_base_reg, 32'h0000b000);
    wr(5'h05, VIEW_WORD, 32'h00001230);
    @(posedge clk);
    base_sel <= 2'h1;
    settle;
    chk(addr_base, 32'h00001230);
  endtask
  task automatic t_pc;
    @(posedge clk);
    pc_load <= 1'b1;
    pc_next <= 32'h00004000;
    wr(5'h10, VIEW_WORD, 32'h00009999);
    chk(next_instr_pointer, 32'h00004000);
    @(posedge clk);
    pc_load <= 1'b0;
    wr(5'h11, VIEW_WORD, 32'h00020000);
    chk(vector_table_base, 32'h00020000);
    wr(5'h10, VIEW_WORD, 32'h00005000);
    chk(next_instr_pointer, 32'h00005000);
  endtask
  task automatic t_stack;
    wr(5'h12, VIEW_WORD, 32'h00003000);
    wr(5'h13, VIEW_WORD, 32'h00002000);
    wr(5'h15, VIEW_WORD, 32'h00000080);
    settle;
    chk(active_stack_pointer, 32'h00003000);
    rd(5'h13, VIEW_WORD, 32'h00002000);
    pulse_int(1'b1, 1'b0, 8'h00);
    chk(processor_flag_word, 32'h0);
    settle;
    chk(active_stack_pointer, 32'h00002000);
    wr(5'h15, VIEW_WORD, 32'h00000080);
    pulse_int(1'b0, 1'b1, 8'h80);
    rd(5'h15, VIEW_WORD, 32'h00000080);
    wr(5'h14, VIEW_WORD, 32'h00003100);
    settle;
    chk(active_stack_pointer, 32'h00003100);
    rd(5'h14, VIEW_WORD, 32'h00003100);
    pulse_int(1'b0, 1'b1, 8'h7f);
    chk(processor_flag_word, 32'h0);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk(active_stack_pointer, 32'h0);
    t_views();
    t_banks();
    t_pc();
    t_stack();
    give_verdict();
  end
  // Tests need under 150 cycles; this leaves wide margin
  initial begin
    #2000000;
    fail_count++;
    give_verdict();
  end
endmodule
